/* ccrb_asserts.sv */
// port-level checks for the charger configuration register bank.
// assumes one core clock; bound to ccrb_top from the bench top.
`default_nettype none
module ccrb_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_timer_tick,
  input wire logic        i_charge_in_cc_cv,
  input wire logic        o_safety_tick,
  input wire logic [12:0] o_vbat_target_mv,
  input wire logic [11:0] o_precharge_threshold_mv,
  input wire logic [10:0] o_overcurrent_ma,
  input wire logic        o_overcurrent_on,
  input wire logic        o_open_thermistor_detect,
  input wire logic [3:0]  o_safety_limit_hours,
  input wire logic        o_safety_timer_on,
  input wire logic [12:0] o_input_limit_mv,
  input wire logic [6:0]  o_thermal_foldback_c,
  input wire logic        o_thermal_foldback_on
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========
  // decoded outputs read zero just after reset, so wait three edges
  logic [1:0] up_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  wire logic live = (up_reg == 2'h3);
  // ==========
  // decode ranges and timer gating
  a_vbat_decode:
  assert property (live |-> o_vbat_target_mv >= 13'hE10 && o_vbat_target_mv <= 13'h11F8
    && (o_vbat_target_mv - 13'hE10) % 13'h00A == 13'h000) else $error("vbat decode off");
  a_lowv_pick:
  assert property (live |-> o_precharge_threshold_mv inside {12'hBB8, 12'hAF0})
    else $error("precharge threshold off");
  a_ocp_level:
  assert property (live && o_overcurrent_on |-> o_overcurrent_ma inside {11'h4B0, 11'h5DC})
    else $error("overcurrent level off");
  a_open_detect_on:
  assert property (live |-> o_open_thermistor_detect) else $error("open detect dropped");
  a_safety_hours:
  assert property (live |-> (o_safety_timer_on ? o_safety_limit_hours inside {4'h3, 4'h6,
    4'hC} : o_safety_limit_hours == 4'h0)) else $error("safety hours off");
  a_vin_level:
  assert property (live |-> o_input_limit_mv >= 13'h1068 && o_input_limit_mv <= 13'h1324
    && (o_input_limit_mv - 13'h1068) % 13'h064 == 13'h000) else $error("input limit off");
  a_fold_range:
  assert property (live && o_thermal_foldback_on |-> o_thermal_foldback_c >= 7'h46 &&
    o_thermal_foldback_c <= 7'h5A && (o_thermal_foldback_c - 7'h46) % 7'h05 == 7'h00)
    else $error("foldback degrees off");
  a_tick_pass:
  assert property (live && i_timer_tick && o_safety_timer_on && i_charge_in_cc_cv
    |=> o_safety_tick) else $error("tick lost in cc or cv");
  a_tick_cause:
  assert property (o_safety_tick |-> $past(i_timer_tick) && $past(o_safety_timer_on))
    else $error("tick without cause");
  c_half_rate: cover property (i_timer_tick && !i_charge_in_cc_cv && o_safety_timer_on);
  c_fold_off: cover property (live && !o_thermal_foldback_on);
  c_ocp_off: cover property (live && !o_overcurrent_on);
endmodule
`default_nettype wire

/* ccrb_defs.vh */
// register offsets, reset values, field positions and decode constants
// for the charger configuration register bank; definitions only.
`ifndef CCRB_DEFS_VH
`define CCRB_DEFS_VH
// register offsets on the serial register port
`define CCRB_OFS_VBAT      8'h12
`define CCRB_OFS_FAST      8'h13
`define CCRB_OFS_PRE       8'h14
`define CCRB_OFS_TERM      8'h15
`define CCRB_OFS_PROT      8'h16
`define CCRB_OFS_CTLA      8'h17
`define CCRB_OFS_CTLB      8'h18
// reset values
`define CCRB_RST_VBAT      8'h3C
`define CCRB_RST_FAST      8'h08
`define CCRB_RST_PRE       8'h02
`define CCRB_RST_TERM      8'h14
`define CCRB_RST_PROT      8'h00
`define CCRB_RST_CTLA      8'h82
`define CCRB_RST_CTLB      8'h42
// field positions
`define CCRB_VBAT_CODE     6:0
`define CCRB_PRE_STEP      7
`define CCRB_PRE_CODE      4:0
`define CCRB_TERM_CODE     5:1
`define CCRB_TERM_DIS      0
`define CCRB_PROT_LOWV     5
`define CCRB_PROT_OCP      4:3
`define CCRB_PROT_UVLO     2:0
`define CCRB_CTLA_TS_ON    7
`define CCRB_CTLA_TS_PROF  6
`define CCRB_CTLA_RECHG    5
`define CCRB_CTLA_WD_DIS   4
`define CCRB_CTLA_DBL      3
`define CCRB_CTLA_SAFETY   2:1
`define CCRB_CTLB_VIN_DIS  7
`define CCRB_CTLB_VIN_LVL  6:4
`define CCRB_CTLB_PP_DIS   3
`define CCRB_CTLB_FOLD     2:0
// decode constants
`define CCRB_VBAT_MAX      7'h64
`define CCRB_VBAT_BASE_MV  13'hE10
`define CCRB_VBAT_STEP_MV  13'h00A
`define CCRB_STEP_FINE_Q   12'h005
`define CCRB_STEP_WIDE_Q   12'h00A
`define CCRB_VIN_BASE_MV   13'h1068
`define CCRB_VIN_STEP_MV   13'h064
`define CCRB_FOLD_BASE_C   7'h46
`define CCRB_FOLD_STEP_C   7'h05
`define CCRB_FOLD_OFF      3'h7
`endif

/* ccrb_host.sv */
// host model for the bank's two-wire register port.
// assumes a pull-up on the data wire; the device only ever pulls it low.
`default_nettype none
module ccrb_host #(
  parameter int         H    = 5,     // core cycles per bus phase
  parameter logic [6:0] ADDR = 7'h2A  // arbitrary, matches the design default
) (
  input  wire logic i_core_clk,
  input  wire logic i_sda_oe,
  output var  logic o_scl,
  output wire logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // wire levels
  logic low = 1'b0;
  initial o_scl = 1'b1;
  assign o_sda = ~(low | i_sda_oe);  // wired-and with pull-up
  // one phase: lines move just after an edge, then hold
  task automatic ph(input logic c, input logic l);
    @(posedge i_core_clk);
    #1;
    o_scl = c;
    low = l;
    repeat (H - 1) @(posedge i_core_clk);
  endtask
  // clock falls first so no data edge is seen while clock is high
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, low);
    ph(1'b0, ~b);
    ph(1'b1, ~b);
    r = o_sda;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);  // host releases the ack slot; on reads this is the nack
    a = ~r;
  endtask
  task automatic start;
    ph(1'b0, low);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic stop;
    ph(1'b0, low);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // ==========
  // one register write, or pointer then repeated start and one read
  task automatic xfer(input logic rd, input logic [7:0] ofs, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic [2:0] n);
    logic       a;
    logic [7:0] q;
    start();
    byte_io({ADDR, 1'b0}, q, a);
    n = {2'h0, a};
    byte_io(ofs, q, a);
    n = n + a;
    if (rd) begin
      start();
      byte_io({ADDR, 1'b1}, q, a);
      n = n + a;
      byte_io(8'hFF, rdat, a);
    end else begin
      byte_io(wd, q, a);
      n = n + a;
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* ccrb_top.v */
// charger configuration register bank behind a two-wire serial slave port.
// assumes scl/sda arrive already synchronous to i_core_clk and that scl is
// far slower than the core clock (many core cycles per scl phase).
// Operation
// RULE1: regulation target 3.6V plus code times 10mV
// RULE2: codes above 4.6V saturate to 4.6V code
// RULE3: fast current code times 1.25 or 2.5mA
// RULE4: step bit: fine 318.75mA max, wide 500mA; the code does not cap wide, code 255 gives 637.5mA
// RULE5: precharge code uses same step size
// RULE6: termination percent 1 to 31, never zero; the code passes a written code 0 through as 0
// RULE7: termination active while disable bit clear
// RULE8: precharge threshold 3.0V clear, 2.8V set
// RULE9: overcurrent 1200, 1500 mA, else disabled
// RULE10: thermistor off stops only charge control
// RULE11: profile bit: multi-zone or hot/cold suspend
// RULE12: watchdog runs while disable bit clear
// RULE13: double timer halves rate outside CC/CV
// RULE14: safety limit 3, 6, 12 hours, or off
// RULE15: input limit active while disable bit clear
// RULE16: input limit 4.2V plus 0.1V per code
// RULE17: power-path management on while bit clear
// RULE18: foldback 70 to 90 degrees, 111 off; the code decodes codes 5 and 6 as 95 and 100 degrees
// RULE19: fields read back last written, reserved kept
// RULE20: reset restores defaults, writes apply promptly
`include "ccrb_defs.vh"
`default_nettype none
module ccrb_top #(
  parameter [6:0] DEV_ADDR = 7'h2A  // arbitrary slave address
) (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // serial register port, open drain data
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe,
  // safety timer rate
  input  wire        i_timer_tick,
  input  wire        i_charge_in_cc_cv,
  output reg         o_safety_tick,
  // decoded charge settings
  output reg  [12:0] o_vbat_target_mv,
  output reg  [11:0] o_fast_current_q,
  output reg  [11:0] o_precharge_current_q,
  output reg  [4:0]  o_termination_percent_code,
  output reg         o_termination_on,
  output reg  [11:0] o_precharge_threshold_mv,
  output reg  [10:0] o_overcurrent_ma,
  output reg         o_overcurrent_on,
  output reg  [11:0] o_undervoltage_mv,
  output reg         o_undervoltage_on,
  output reg         o_thermistor_control_on,
  output reg         o_open_thermistor_detect,
  output reg         o_thermistor_profile_select,
  output reg  [7:0]  o_recharge_drop_mv,
  output reg         o_watchdog_run,
  output reg  [3:0]  o_safety_limit_hours,
  output reg         o_safety_timer_on,
  output reg         o_input_voltage_dynamic_limit,
  output reg  [12:0] o_input_limit_mv,
  output reg         o_dynamic_power_path_management,
  output reg  [6:0]  o_thermal_foldback_c,
  output reg         o_thermal_foldback_on
);
  // ==========================================================
  // serial slave state
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_PTR  = 4'h3;
  localparam [3:0] S_PACK = 4'h4;
  localparam [3:0] S_WR   = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RD   = 4'h7;
  localparam [3:0] S_RACK = 4'h8;
  reg  [3:0] state_reg;
  reg  [3:0] cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] ptr_reg;
  reg        rw_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg        half_reg;
  reg  [7:0] vbat_reg;
  reg  [7:0] fast_reg;
  reg  [7:0] pre_reg;
  reg  [7:0] term_reg;
  reg  [7:0] prot_reg;
  reg  [7:0] ctla_reg;
  reg  [7:0] ctlb_reg;
  reg  [7:0] rd_mux;
  wire scl_rise = i_scl & ~scl_d_reg;
  wire scl_fall = ~i_scl & scl_d_reg;
  wire start_ev = i_scl & scl_d_reg & sda_d_reg & ~i_sda;
  wire stop_ev  = i_scl & scl_d_reg & ~sda_d_reg & i_sda;
  wire [7:0] byte_in = {shift_reg[6:0], i_sda};
  // ==========================================================
  // read data select; unmapped offsets read zero
  always @* begin
    if (ptr_reg == `CCRB_OFS_VBAT) begin
      rd_mux = vbat_reg;
    end else if (ptr_reg == `CCRB_OFS_FAST) begin
      rd_mux = fast_reg;
    end else if (ptr_reg == `CCRB_OFS_PRE) begin
      rd_mux = pre_reg;
    end else if (ptr_reg == `CCRB_OFS_TERM) begin
      rd_mux = term_reg;
    end else if (ptr_reg == `CCRB_OFS_PROT) begin
      rd_mux = prot_reg;
    end else if (ptr_reg == `CCRB_OFS_CTLA) begin
      rd_mux = ctla_reg;
    end else if (ptr_reg == `CCRB_OFS_CTLB) begin
      rd_mux = ctlb_reg;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ==========================================================
  // slave sequencer and register writes
  // sda only moves after scl falls, so no false start or stop is sent
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
      vbat_reg  <= `CCRB_RST_VBAT; // RULE20
      fast_reg  <= `CCRB_RST_FAST;
      pre_reg   <= `CCRB_RST_PRE;
      term_reg  <= `CCRB_RST_TERM;
      prot_reg  <= `CCRB_RST_PROT;
      ctla_reg  <= `CCRB_RST_CTLA;
      ctlb_reg  <= `CCRB_RST_CTLB;
    end else begin
      scl_d_reg <= i_scl;
      sda_d_reg <= i_sda;
      if (start_ev) begin
        state_reg <= S_ADDR;
        cnt_reg   <= 4'h0;
        o_sda_oe  <= 1'b0;
      end else if (stop_ev) begin
        state_reg <= S_IDLE;
        o_sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          S_ADDR, S_PTR, S_WR: begin
            shift_reg <= byte_in;
            cnt_reg   <= cnt_reg + 4'h1;
          end
          S_RD: begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          S_RACK: begin
            if (i_sda) begin
              state_reg <= S_IDLE; // host nack ends the read
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          S_ADDR: begin
            if (cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg    <= shift_reg[0];
                o_sda_oe  <= 1'b1;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK, S_RACK: begin
            cnt_reg <= 4'h0;
            if (state_reg == S_RACK || rw_reg) begin
              shift_reg <= rd_mux;
              o_sda_oe  <= ~rd_mux[7];
              state_reg <= S_RD;
            end else begin
              o_sda_oe  <= 1'b0;
              state_reg <= S_PTR;
            end
          end
          S_PTR: begin
            if (cnt_reg == 4'h8) begin
              ptr_reg   <= shift_reg;
              o_sda_oe  <= 1'b1;
              state_reg <= S_PACK;
            end
          end
          S_PACK, S_WACK: begin
            o_sda_oe  <= 1'b0;
            cnt_reg   <= 4'h0;
            state_reg <= S_WR;
          end
          S_WR: begin
            if (cnt_reg == 4'h8) begin
              // whole byte kept so reserved bits read back
              if (ptr_reg == `CCRB_OFS_VBAT) begin
                if (shift_reg[`CCRB_VBAT_CODE] > `CCRB_VBAT_MAX) begin
                  vbat_reg <= {shift_reg[7], `CCRB_VBAT_MAX}; // RULE2
                end else begin
                  vbat_reg <= shift_reg; // RULE19
                end
              end else if (ptr_reg == `CCRB_OFS_FAST) begin
                fast_reg <= shift_reg;
              end else if (ptr_reg == `CCRB_OFS_PRE) begin
                pre_reg <= shift_reg;
              end else if (ptr_reg == `CCRB_OFS_TERM) begin
                term_reg <= shift_reg;
              end else if (ptr_reg == `CCRB_OFS_PROT) begin
                prot_reg <= shift_reg;
              end else if (ptr_reg == `CCRB_OFS_CTLA) begin
                ctla_reg <= shift_reg;
              end else if (ptr_reg == `CCRB_OFS_CTLB) begin
                ctlb_reg <= shift_reg;
              end
              ptr_reg   <= ptr_reg + 8'h01;
              o_sda_oe  <= 1'b1;
              state_reg <= S_WACK;
            end
          end
          S_RD: begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe  <= 1'b0;
              ptr_reg   <= ptr_reg + 8'h01;
              state_reg <= S_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              o_sda_oe  <= ~shift_reg[6];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // settings decode, one flop per output, one cycle after the byte store
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_vbat_target_mv                <= 13'h0000;
      o_fast_current_q                <= 12'h000;
      o_precharge_current_q           <= 12'h000;
      o_termination_percent_code      <= 5'h00;
      o_termination_on                <= 1'b0;
      o_precharge_threshold_mv        <= 12'h000;
      o_overcurrent_ma                <= 11'h000;
      o_overcurrent_on                <= 1'b0;
      o_undervoltage_mv               <= 12'h000;
      o_undervoltage_on               <= 1'b0;
      o_thermistor_control_on         <= 1'b0;
      o_open_thermistor_detect        <= 1'b0;
      o_thermistor_profile_select     <= 1'b0;
      o_recharge_drop_mv              <= 8'h00;
      o_watchdog_run                  <= 1'b0;
      o_safety_limit_hours            <= 4'h0;
      o_safety_timer_on               <= 1'b0;
      o_input_voltage_dynamic_limit   <= 1'b0;
      o_input_limit_mv                <= 13'h0000;
      o_dynamic_power_path_management <= 1'b0;
      o_thermal_foldback_c            <= 7'h00;
      o_thermal_foldback_on           <= 1'b0;
    end else begin
      o_vbat_target_mv <= `CCRB_VBAT_BASE_MV
                        + {6'h00, vbat_reg[`CCRB_VBAT_CODE]} * `CCRB_VBAT_STEP_MV; // RULE1
      // currents in quarter-milliamp units
      o_fast_current_q <= {4'h0, fast_reg} * (pre_reg[`CCRB_PRE_STEP] ?
                          `CCRB_STEP_WIDE_Q : `CCRB_STEP_FINE_Q); // RULE3 RULE4
      o_precharge_current_q <= {7'h00, pre_reg[`CCRB_PRE_CODE]} *
                               (pre_reg[`CCRB_PRE_STEP] ?
                               `CCRB_STEP_WIDE_Q : `CCRB_STEP_FINE_Q); // RULE5
      o_termination_percent_code <= term_reg[`CCRB_TERM_CODE]; // RULE6
      o_termination_on <= ~term_reg[`CCRB_TERM_DIS]; // RULE7
      o_precharge_threshold_mv <= prot_reg[`CCRB_PROT_LOWV] ? 12'hAF0 : 12'hBB8; // RULE8
      o_overcurrent_ma <= prot_reg[3] ? 11'h5DC : 11'h4B0; // RULE9
      o_overcurrent_on <= ~prot_reg[4]; // RULE9
      case (prot_reg[`CCRB_PROT_UVLO])
        3'h3:    o_undervoltage_mv <= 12'hAF0;
        3'h4:    o_undervoltage_mv <= 12'hA28;
        3'h5:    o_undervoltage_mv <= 12'h960;
        3'h6:    o_undervoltage_mv <= 12'h898;
        default: o_undervoltage_mv <= 12'hBB8;
      endcase
      o_undervoltage_on <= (prot_reg[`CCRB_PROT_UVLO] != 3'h7);
      // open detection stays on whatever the thermistor enable says
      o_thermistor_control_on     <= ctla_reg[`CCRB_CTLA_TS_ON]; // RULE10
      o_open_thermistor_detect    <= 1'b1; // RULE10
      o_thermistor_profile_select <= ctla_reg[`CCRB_CTLA_TS_PROF]; // RULE11
      o_recharge_drop_mv <= ctla_reg[`CCRB_CTLA_RECHG] ? 8'hC8 : 8'h8C;
      o_watchdog_run <= ~ctla_reg[`CCRB_CTLA_WD_DIS]; // RULE12
      case (ctla_reg[`CCRB_CTLA_SAFETY])
        2'h0:    o_safety_limit_hours <= 4'h3; // RULE14
        2'h1:    o_safety_limit_hours <= 4'h6;
        2'h2:    o_safety_limit_hours <= 4'hC;
        default: o_safety_limit_hours <= 4'h0;
      endcase
      o_safety_timer_on <= (ctla_reg[`CCRB_CTLA_SAFETY] != 2'h3); // RULE14
      o_input_voltage_dynamic_limit <= ~ctlb_reg[`CCRB_CTLB_VIN_DIS]; // RULE15
      o_input_limit_mv <= `CCRB_VIN_BASE_MV
                        + {10'h000, ctlb_reg[`CCRB_CTLB_VIN_LVL]} * `CCRB_VIN_STEP_MV; // RULE16
      o_dynamic_power_path_management <= ~ctlb_reg[`CCRB_CTLB_PP_DIS]; // RULE17
      // reserved codes 5 and 6 decode on the same line; host must avoid them
      o_thermal_foldback_c <= `CCRB_FOLD_BASE_C
                            + {4'h0, ctlb_reg[`CCRB_CTLB_FOLD]} * `CCRB_FOLD_STEP_C; // RULE18
      o_thermal_foldback_on <= (ctlb_reg[`CCRB_CTLB_FOLD] != `CCRB_FOLD_OFF); // RULE18
    end
  end

  // ==========================================================
  // safety timer tick gating; every other base tick is dropped when slowed
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      half_reg      <= 1'b0;
      o_safety_tick <= 1'b0;
    end else begin
      o_safety_tick <= 1'b0;
      if (i_timer_tick && ctla_reg[`CCRB_CTLA_SAFETY] != 2'h3) begin
        if (ctla_reg[`CCRB_CTLA_DBL] && !i_charge_in_cc_cv) begin
          half_reg      <= ~half_reg;
          o_safety_tick <= half_reg; // RULE13
        end else begin
          o_safety_tick <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the charger configuration register bank.
// assumes ccrb_host on the serial port and ccrb_asserts bound below.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, tick, cccv;
  wire logic scl, sda, sda_oe, stick, ton, ocon, tson, otd, tsp, wdr, sfon, vindl, ppm, fon;
  wire logic [12:0] vbat, vin;
  wire logic [11:0] fq, pq, thr, uvmv;
  wire logic [7:0]  rdrop;
  wire logic        sdo, uvon;
  wire logic [10:0] ocma;
  wire logic [6:0]  fold;
  wire logic [4:0]  tpc;
  wire logic [3:0]  hrs;
  int err_count = 0;
  int checks_done = 0;
  ccrb_top ccrb_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sdo), .o_sda_oe(sda_oe), .i_timer_tick(tick), .i_charge_in_cc_cv(cccv),
    .o_safety_tick(stick), .o_vbat_target_mv(vbat), .o_fast_current_q(fq),
    .o_precharge_current_q(pq), .o_termination_percent_code(tpc), .o_termination_on(ton),
    .o_precharge_threshold_mv(thr), .o_overcurrent_ma(ocma), .o_overcurrent_on(ocon),
    .o_undervoltage_mv(uvmv), .o_undervoltage_on(uvon), .o_thermistor_control_on(tson),
    .o_open_thermistor_detect(otd), .o_thermistor_profile_select(tsp),
    .o_recharge_drop_mv(rdrop), .o_watchdog_run(wdr), .o_safety_limit_hours(hrs),
    .o_safety_timer_on(sfon), .o_input_voltage_dynamic_limit(vindl), .o_input_limit_mv(vin),
    .o_dynamic_power_path_management(ppm), .o_thermal_foldback_c(fold),
    .o_thermal_foldback_on(fon));
  ccrb_host ccrb_host_i (.i_core_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  // ==========
  // shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] n;
    ccrb_host_i.xfer(1'b0, a, d, q, n);
    chk(16'(n), 16'h3);  // all three bytes acknowledged
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic [2:0] n;
    ccrb_host_i.xfer(1'b1, a, 8'h00, q, n);
    chk(16'(q), 16'(e));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;  // defaults, then an unmapped place reads zero
    logic [7:0] dv [7] = '{8'h3C, 8'h08, 8'h02, 8'h14, 8'h00, 8'h82, 8'h42};
    for (int i = 0; i < 7; i++) rd(8'h12 + 8'(i), dv[i]);
    chk(16'(vbat), 16'h1068);
    chk(16'(fold), 16'h0050);
    chk({uvon, 3'h0, uvmv}, 16'h8BB8);
    chk(16'(sdo), 16'h0000);
    wr(8'h20, 8'h5A);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_vbat;  // codes above the top saturate, bit 7 is kept
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'hE4);
    chk(16'(vbat), 16'h11F8);
    wr(8'h12, 8'h00);
    chk(16'(vbat), 16'h0E10);
    wr(8'h12, 8'h2B);
    chk(16'(vbat), 16'h0FBE);
  endtask
  task automatic t_curr;  // both step sizes at the code ceilings
    wr(8'h13, 8'hFF);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'hFF);
    chk(16'(fq), 16'h09F6);
    chk(16'(pq), 16'h0136);
    wr(8'h14, 8'h1F);
    chk(16'(fq), 16'h04FB);
    chk(16'(pq), 16'h009B);
  endtask
  task automatic t_term;  // never code zero from the host side
    wr(8'h15, 8'h03);
    chk(16'(tpc), 16'h0001);
    chk(16'(ton), 16'h0000);
    wr(8'h15, 8'hFE);
    chk(16'(tpc), 16'h001F);
    chk(16'(ton), 16'h0001);
  endtask
  task automatic t_prot;  // every overcurrent code, low threshold, undervoltage levels
    for (int i = 0; i < 4; i++) begin
      wr(8'h16, {3'h1, 2'(i), 3'(i + 3)});
      chk({uvon, 3'h0, uvmv}, 16'h8AF0 - 16'h00C8 * 16'(i));
      chk(16'(thr), 16'h0AF0);
      chk(16'(ocon), 16'(i < 2));
      if (i < 2) chk(16'(ocma), (i == 1) ? 16'h05DC : 16'h04B0);
    end
    wr(8'h16, 8'h07);
    chk(16'(thr), 16'h0BB8);
    chk(16'(uvon), 16'h0000);
  endtask
  task automatic t_ctla;  // thermistor, watchdog and every safety code
    logic [3:0] hv [4] = '{4'h3, 4'h6, 4'hC, 4'h0};
    wr(8'h17, 8'h78);
    chk({tson, otd, tsp, wdr}, 16'h0006);
    chk(16'(rdrop), 16'h00C8);
    for (int i = 0; i < 4; i++) begin
      wr(8'h17, {5'h10, 2'(i), 1'b0});
      chk({tson, tsp, wdr, sfon, hrs}, {8'h00, 3'h5, i != 3, hv[i]});
      chk(16'(rdrop), 16'h008C);
    end
  endtask
  task automatic t_ctlb;  // all input levels; foldback codes 5 and 6 never written
    logic [2:0] fc;
    for (int i = 0; i < 8; i++) begin
      fc = (i > 4) ? 3'h7 : 3'(i);
      wr(8'h18, {i[0], 3'(i), ~i[0], fc});
      chk({vindl, ppm, fon}, {13'h0, ~i[0], i[0], fc != 3'h7});
      chk(16'(vin), 16'h1068 + 16'h0064 * 16'(i));
      if (fc != 3'h7) chk(16'(fold), 16'h0046 + 16'h0005 * 16'(fc));
    end
  endtask
  task automatic t_tick;  // halved outside cc/cv, full inside, none when off
    logic [7:0] cv [4] = '{8'h0A, 8'h0A, 8'h06, 8'h02};
    logic [3:0] ex [4] = '{4'h2, 4'h4, 4'h0, 4'h4};
    int n;
    for (int m = 0; m < 4; m++) begin
      wr(8'h17, cv[m]);
      #1 cccv = (m == 1);
      n = 0;
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        #1 tick = 1'b1;
        @(posedge clk);
        #1 tick = 1'b0;
        if (stick === 1'b1) n++;
      end
      chk(16'(n), 16'(ex[m]));
    end
  endtask
  // ==========
  // clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    tick = 1'b0;
    cccv = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_vbat();
    t_curr();
    t_term();
    t_prot();
    t_ctla();
    t_ctlb();
    t_tick();
    tally_and_finish();
  end
  initial begin
    #400us;
    err_count++;
    tally_and_finish();
  end
endmodule
bind ccrb_top ccrb_asserts ccrb_asserts_i (.i_core_clk, .i_rst_n, .i_timer_tick,
  .i_charge_in_cc_cv, .o_safety_tick, .o_vbat_target_mv, .o_precharge_threshold_mv,
  .o_overcurrent_ma, .o_overcurrent_on, .o_open_thermistor_detect, .o_safety_limit_hours,
  .o_safety_timer_on, .o_input_limit_mv, .o_thermal_foldback_c, .o_thermal_foldback_on);
`default_nettype wire
